// >>> limit_aux_pkg.sv
// shared constants for the travel-limit and auxiliary pin controller
package limit_aux_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_LIMIT_CFG = 8'h00;
	localparam logic [7:0] OFS_LEFT_POS = 8'h04;
	localparam logic [7:0] OFS_LEFT_FRAC = 8'h08;
	localparam logic [7:0] OFS_RIGHT_POS = 8'h0c;
	localparam logic [7:0] OFS_RIGHT_FRAC = 8'h10;
	localparam logic [7:0] OFS_AUX_CFG = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_QUERY_CMD = 8'h1c;
	localparam logic [7:0] OFS_QUERY_DATA = 8'h20;
	localparam logic [7:0] OFS_QUERY_LEFT = 8'h24;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [31:0] RST_POS = 32'h0000_0000;
	localparam logic [15:0] RST_FRAC = 16'h0000;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int LIM_FROM_POS = 0;
	localparam int STOP_LEFT = 1;
	localparam int STOP_RIGHT = 2;
	localparam int STOP_BOTH = 3;
	localparam int SW_SWAP = 0;
	localparam int SW1_LOW = 1;
	localparam int SW2_LOW = 2;
	localparam int AUX_IS_OUT = 0;
	localparam int AUX_INVERT = 1;
	// ----------------------------------------
	// aux action and output source codes (nibbles)
	// ----------------------------------------
	localparam logic [3:0] ACT_STOP = 4'h1;
	localparam logic [3:0] ACT_WIND_OFF = 4'h2;
	localparam logic [3:0] ACT_REL_MOVE = 4'h3;
	localparam logic [3:0] ACT_HOME = 4'h4;
	localparam logic [3:0] ACT_ALARM = 4'h5;
	localparam logic [3:0] OUT_ON = 4'h1;
	localparam logic [3:0] OUT_MOVING = 4'h2;
	localparam logic [3:0] OUT_ALARM = 4'h3;
	localparam logic [3:0] OUT_WIND_ON = 4'h4;
	localparam logic [3:0] OUT_FOUND = 4'h5;
	// ----------------------------------------
	// query exchange
	// ----------------------------------------
	localparam logic [31:0] CMD_READ_LIMITS = 32'h7364_6567;
	localparam logic [31:0] CMD_READ_AUX = 32'h6f69_6567;
	localparam logic [4:0] LEN_LIMITS = 5'h1a;
	localparam logic [4:0] LEN_AUX = 5'h12;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// one-hot query states
	typedef enum logic [1:0] {Q_IDLE = 2'h1, Q_SEND = 2'h2} query_state_t;
endpackage

// >>> crc_link_if.sv
// byte feed between the answer builder and its checksum engine
interface crc_link_if;
	logic clear; // restart the checksum
	logic load; // fold data into the checksum
	logic [7:0] data;
	logic [15:0] crc;
	modport source(output clear, output load, output data, input crc);
	modport engine(input clear, input load, input data, output crc);
endinterface

// >>> answer_crc.sv
// byte-wise 16-bit checksum engine for query answers
module answer_crc (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// byte feed
	crc_link_if.engine link
);
	logic [15:0] crc; // running checksum
	logic [15:0] next_crc;

	// eight reflected shift steps per byte
	always_comb begin
		next_crc = crc ^ {8'h00, link.data};
		for (int i = 0; i < 8; i++) begin
			if (next_crc[0]) begin
				next_crc = (next_crc >> 1) ^ limit_aux_pkg::CRC_POLY;
			end else begin
				next_crc = next_crc >> 1;
			end
		end
	end

	// clear has priority so a new query never mixes with an old one
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i || link.clear) begin
			crc <= limit_aux_pkg::CRC_INIT;
		end else if (link.load) begin
			crc <= next_crc;
		end
	end

	assign link.crc = crc;
endmodule

// >>> limit_aux_ctrl.sv
// travel-limit supervision, aux pin control and settings query, axi4-lite slave
//
// Function
// - flag 0x1 selects position limits over switches
// - flag 0x2 halts at left limit
// - flag 0x4 halts at right limit
// - flag 0x8 halts at either limit
// - swap flag makes first switch the right one
// - switch flags 0x2/0x4 select low-true pins
// - left limit: signed 32 plus 16 fraction
// - right limit: signed 32 plus 16 fraction
// - setup bit 0x1 drives aux pin out
// - setup bit 0x2 inverts aux pin sense
// - low mode nibble picks input action
// - action 0x1 stops the motor
// - action 0x2 removes winding power
// - action 0x3 relative move, 0x4 homing
// - action 0x5 raises the alarm
// - high nibble 0x0 off, 0x10 on
// - output 0x20 follows moving state
// - output 0x30 follows alarm state
// - output 0x40 follows energised windings
// - output 0x50 follows motor found
// - limits query gives 26-byte answer, checksummed
// - aux query gives 18-byte answer, checksummed
//
// Our own choices: the register addresses and register access over AXI4-Lite.
module limit_aux_ctrl (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// axi4-lite write channels
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// axi4-lite read channels
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// motion state from the controller core
	input wire logic [31:0] position_i,
	input wire logic [15:0] position_fraction_i,
	input wire logic motor_moving_i,
	input wire logic alarm_state_i,
	input wire logic windings_on_i,
	input wire logic motor_found_i,
	// limit switches
	input wire logic first_switch_pin_i,
	input wire logic second_switch_pin_i,
	// auxiliary pin
	input wire logic aux_io_pin_i,
	output logic aux_io_pin_o,
	output logic aux_io_pin_oe_o,
	// supervision and commands to the motion core
	output logic at_left_limit_o,
	output logic at_right_limit_o,
	output logic halt_motor_o,
	output logic stop_command_o,
	output logic windings_off_command_o,
	output logic relative_move_command_o,
	output logic home_command_o,
	output logic alarm_set_o
);
	// ----------------------------------------
	// settings registers
	// ----------------------------------------
	logic [7:0] travel_limit_flags;
	logic [7:0] switch_config_flags;
	logic [31:0] left_limit_pos;
	logic [15:0] left_limit_fraction;
	logic [31:0] right_limit_pos;
	logic [15:0] right_limit_fraction;
	logic [7:0] aux_pin_setup;
	logic [7:0] aux_pin_mode_byte;

	// ----------------------------------------
	// bus state
	// ----------------------------------------
	logic [7:0] aw_addr; // held write address
	logic [31:0] w_data; // held write data
	logic [3:0] w_strb;
	logic aw_taken;
	logic w_taken;
	logic ar_take;
	logic wr_fire;

	assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
	assign wr_fire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
	assign aw_taken = s_axi_awvalid_i && s_axi_awready_o;
	assign w_taken = s_axi_wvalid_i && s_axi_wready_o;

	// merge byte lanes into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = val[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// position in 1/256 microsteps, wide enough that no sum overflows
	function automatic logic signed [40:0] fine(input logic [31:0] pos,
			input logic [15:0] frac);
		return 41'($signed({pos, 8'h00})) + 41'($signed(frac));
	endfunction

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic [31:0] cfg_word;
	logic [31:0] lim_old;
	logic [31:0] aux_old;
	logic [31:0] wr_merged;
	logic wr_hit;
	assign lim_old = {16'h0000, switch_config_flags, travel_limit_flags};
	assign aux_old = {16'h0000, aux_pin_mode_byte, aux_pin_setup};
	assign cfg_word = (aw_addr == limit_aux_pkg::OFS_LIMIT_CFG) ? lim_old : aux_old;
	assign wr_merged = merge(cfg_word, w_data, w_strb);
	assign wr_hit = (aw_addr == limit_aux_pkg::OFS_LIMIT_CFG)
		|| (aw_addr == limit_aux_pkg::OFS_LEFT_POS)
		|| (aw_addr == limit_aux_pkg::OFS_LEFT_FRAC)
		|| (aw_addr == limit_aux_pkg::OFS_RIGHT_POS)
		|| (aw_addr == limit_aux_pkg::OFS_RIGHT_FRAC)
		|| (aw_addr == limit_aux_pkg::OFS_AUX_CFG)
		|| (aw_addr == limit_aux_pkg::OFS_QUERY_CMD);

	// channel handshakes: each ready drops once its item is held
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= limit_aux_pkg::RESP_OKAY;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (aw_taken) begin
				s_axi_awready_o <= 1'b0;
				aw_addr <= s_axi_awaddr_i;
			end
			if (w_taken) begin
				s_axi_wready_o <= 1'b0;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_hit ? limit_aux_pkg::RESP_OKAY : limit_aux_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	// settings writes
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			travel_limit_flags <= limit_aux_pkg::RST_FLAGS;
			switch_config_flags <= limit_aux_pkg::RST_FLAGS;
			left_limit_pos <= limit_aux_pkg::RST_POS;
			left_limit_fraction <= limit_aux_pkg::RST_FRAC;
			right_limit_pos <= limit_aux_pkg::RST_POS;
			right_limit_fraction <= limit_aux_pkg::RST_FRAC;
			aux_pin_setup <= limit_aux_pkg::RST_FLAGS;
			aux_pin_mode_byte <= limit_aux_pkg::RST_FLAGS;
		end else if (wr_fire) begin
			case (aw_addr)
				limit_aux_pkg::OFS_LIMIT_CFG: begin
					{switch_config_flags, travel_limit_flags} <= wr_merged[15:0];
				end
				limit_aux_pkg::OFS_LEFT_POS: begin
					left_limit_pos <= merge(left_limit_pos, w_data, w_strb);
				end
				limit_aux_pkg::OFS_LEFT_FRAC: begin
					left_limit_fraction <= frac_merge(left_limit_fraction);
				end
				limit_aux_pkg::OFS_RIGHT_POS: begin
					right_limit_pos <= merge(right_limit_pos, w_data, w_strb);
				end
				limit_aux_pkg::OFS_RIGHT_FRAC: begin
					right_limit_fraction <= frac_merge(right_limit_fraction);
				end
				limit_aux_pkg::OFS_AUX_CFG: begin
					{aux_pin_mode_byte, aux_pin_setup} <= wr_merged[15:0];
				end
				default: begin
					// query command and unmapped addresses hold no settings
				end
			endcase
		end
	end

	// low half-word merge for the fraction registers
	function automatic logic [15:0] frac_merge(input logic [15:0] old);
		logic [31:0] res;
		res = merge({16'h0000, old}, w_data, w_strb);
		return res[15:0];
	endfunction

	// ----------------------------------------
	// limit supervision
	// ----------------------------------------
	logic sw1_act;
	logic sw2_act;
	logic left_sw;
	logic right_sw;
	logic at_left;
	logic at_right;
	logic next_halt;
	assign sw1_act = first_switch_pin_i ^ switch_config_flags[limit_aux_pkg::SW1_LOW];
	assign sw2_act = second_switch_pin_i ^ switch_config_flags[limit_aux_pkg::SW2_LOW];
	assign left_sw = switch_config_flags[limit_aux_pkg::SW_SWAP] ? sw2_act : sw1_act;
	assign right_sw = switch_config_flags[limit_aux_pkg::SW_SWAP] ? sw1_act : sw2_act;
	// fine comparison uses the fraction too; servo cores simply report zero there
	assign at_left = travel_limit_flags[limit_aux_pkg::LIM_FROM_POS]
		? (fine(position_i, position_fraction_i) <= fine(left_limit_pos, left_limit_fraction))
		: left_sw;
	assign at_right = travel_limit_flags[limit_aux_pkg::LIM_FROM_POS]
		? (fine(position_i, position_fraction_i) >= fine(right_limit_pos, right_limit_fraction))
		: right_sw;
	assign next_halt = (travel_limit_flags[limit_aux_pkg::STOP_LEFT] && at_left)
		|| (travel_limit_flags[limit_aux_pkg::STOP_RIGHT] && at_right)
		|| (travel_limit_flags[limit_aux_pkg::STOP_BOTH] && (at_left || at_right));

	// ----------------------------------------
	// auxiliary pin
	// ----------------------------------------
	logic aux_is_out;
	logic aux_sense;
	logic aux_prev; // last sensed level for edge detection
	logic aux_event;
	logic [3:0] in_action;
	logic [3:0] out_source;
	logic aux_active;
	assign aux_is_out = aux_pin_setup[limit_aux_pkg::AUX_IS_OUT];
	assign aux_sense = aux_io_pin_i ^ aux_pin_setup[limit_aux_pkg::AUX_INVERT];
	assign aux_event = !aux_is_out && aux_sense && !aux_prev;
	assign in_action = aux_pin_mode_byte[3:0];
	assign out_source = aux_pin_mode_byte[7:4];
	// unknown source codes leave the pin inactive
	assign aux_active = (out_source == limit_aux_pkg::OUT_ON)
		|| ((out_source == limit_aux_pkg::OUT_MOVING) && motor_moving_i)
		|| ((out_source == limit_aux_pkg::OUT_ALARM) && alarm_state_i)
		|| ((out_source == limit_aux_pkg::OUT_WIND_ON) && windings_on_i)
		|| ((out_source == limit_aux_pkg::OUT_FOUND) && motor_found_i);

	// registered supervision and one-cycle action pulses; unknown actions do nothing
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			aux_prev <= 1'b0;
			at_left_limit_o <= 1'b0;
			at_right_limit_o <= 1'b0;
			halt_motor_o <= 1'b0;
			stop_command_o <= 1'b0;
			windings_off_command_o <= 1'b0;
			relative_move_command_o <= 1'b0;
			home_command_o <= 1'b0;
			alarm_set_o <= 1'b0;
			aux_io_pin_o <= 1'b0;
			aux_io_pin_oe_o <= 1'b0;
		end else begin
			aux_prev <= aux_sense;
			at_left_limit_o <= at_left;
			at_right_limit_o <= at_right;
			halt_motor_o <= next_halt;
			stop_command_o <= aux_event && (in_action == limit_aux_pkg::ACT_STOP);
			windings_off_command_o <= aux_event
				&& (in_action == limit_aux_pkg::ACT_WIND_OFF);
			relative_move_command_o <= aux_event
				&& (in_action == limit_aux_pkg::ACT_REL_MOVE);
			home_command_o <= aux_event && (in_action == limit_aux_pkg::ACT_HOME);
			alarm_set_o <= aux_event && (in_action == limit_aux_pkg::ACT_ALARM);
			aux_io_pin_o <= aux_is_out && (aux_active ^ aux_pin_setup[limit_aux_pkg::AUX_INVERT]);
			aux_io_pin_oe_o <= aux_is_out;
		end
	end

	// ----------------------------------------
	// settings query
	// ----------------------------------------
	limit_aux_pkg::query_state_t query_state;
	logic [31:0] query_cmd;
	logic [4:0] query_idx; // next answer byte
	logic [4:0] query_len;
	logic [191:0] answer_vec;
	logic [7:0] answer_byte;
	logic is_limits;
	logic cmd_write;
	logic pop;
	crc_link_if crc_link();

	// answers are little-endian; trailing reserved bytes are zero
	assign is_limits = (query_cmd == limit_aux_pkg::CMD_READ_LIMITS);
	assign answer_vec = is_limits
		? {48'h0, right_limit_fraction, right_limit_pos, left_limit_fraction, left_limit_pos,
			switch_config_flags, travel_limit_flags, query_cmd}
		: {144'h0, aux_pin_mode_byte, aux_pin_setup, query_cmd};
	assign answer_byte = (query_idx == query_len - 5'h02) ? crc_link.crc[7:0]
		: (query_idx == query_len - 5'h01) ? crc_link.crc[15:8]
		: answer_vec[{query_idx, 3'h0} +: 8];
	assign cmd_write = wr_fire && (aw_addr == limit_aux_pkg::OFS_QUERY_CMD);
	assign pop = ar_take && (s_axi_araddr_i == limit_aux_pkg::OFS_QUERY_DATA)
		&& (query_state == limit_aux_pkg::Q_SEND);
	assign crc_link.clear = cmd_write;
	assign crc_link.load = pop && (query_idx < query_len - 5'h02);
	assign crc_link.data = answer_byte;

	answer_crc crc_engine (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.link(crc_link.engine)
	);

	// a new command restarts the answer; an unknown code yields none
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			query_state <= limit_aux_pkg::Q_IDLE;
			query_cmd <= 32'h0000_0000;
			query_idx <= 5'h00;
			query_len <= 5'h00;
		end else if (cmd_write) begin
			query_cmd <= w_data;
			query_idx <= 5'h00;
			case (w_data)
				limit_aux_pkg::CMD_READ_LIMITS: begin
					query_len <= limit_aux_pkg::LEN_LIMITS;
					query_state <= limit_aux_pkg::Q_SEND;
				end
				limit_aux_pkg::CMD_READ_AUX: begin
					query_len <= limit_aux_pkg::LEN_AUX;
					query_state <= limit_aux_pkg::Q_SEND;
				end
				default: begin
					query_len <= 5'h00;
					query_state <= limit_aux_pkg::Q_IDLE;
				end
			endcase
		end else if (pop) begin
			query_idx <= query_idx + 5'h01;
			if (query_idx == query_len - 5'h01) begin
				query_state <= limit_aux_pkg::Q_IDLE;
			end
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	logic [31:0] rd_data;
	logic rd_hit;
	logic sending;
	assign sending = (query_state == limit_aux_pkg::Q_SEND);
	assign rd_hit = wr_hit_r(s_axi_araddr_i) || (s_axi_araddr_i == limit_aux_pkg::OFS_STATUS)
		|| (s_axi_araddr_i == limit_aux_pkg::OFS_QUERY_DATA)
		|| (s_axi_araddr_i == limit_aux_pkg::OFS_QUERY_LEFT);
	assign rd_data = (s_axi_araddr_i == limit_aux_pkg::OFS_LIMIT_CFG) ? lim_old
		: (s_axi_araddr_i == limit_aux_pkg::OFS_LEFT_POS) ? left_limit_pos
		: (s_axi_araddr_i == limit_aux_pkg::OFS_LEFT_FRAC) ? {16'h0000, left_limit_fraction}
		: (s_axi_araddr_i == limit_aux_pkg::OFS_RIGHT_POS) ? right_limit_pos
		: (s_axi_araddr_i == limit_aux_pkg::OFS_RIGHT_FRAC) ? {16'h0000, right_limit_fraction}
		: (s_axi_araddr_i == limit_aux_pkg::OFS_AUX_CFG) ? aux_old
		: (s_axi_araddr_i == limit_aux_pkg::OFS_STATUS)
			? {27'h0, aux_io_pin_o, aux_sense, halt_motor_o, at_right_limit_o, at_left_limit_o}
		: (s_axi_araddr_i == limit_aux_pkg::OFS_QUERY_CMD) ? query_cmd
		: (s_axi_araddr_i == limit_aux_pkg::OFS_QUERY_DATA)
			? {23'h0, sending, sending ? answer_byte : 8'h00}
		: (s_axi_araddr_i == limit_aux_pkg::OFS_QUERY_LEFT) ? {27'h0, query_len - query_idx}
		: 32'h0000_0000;

	// readable settings offsets, shared with the write decode
	function automatic logic wr_hit_r(input logic [7:0] a);
		return (a == limit_aux_pkg::OFS_LIMIT_CFG) || (a == limit_aux_pkg::OFS_LEFT_POS)
			|| (a == limit_aux_pkg::OFS_LEFT_FRAC) || (a == limit_aux_pkg::OFS_RIGHT_POS)
			|| (a == limit_aux_pkg::OFS_RIGHT_FRAC) || (a == limit_aux_pkg::OFS_AUX_CFG)
			|| (a == limit_aux_pkg::OFS_QUERY_CMD);
	endfunction

	// one read at a time; data captured at the address handshake
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= limit_aux_pkg::RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd_data;
			s_axi_rresp_o <= rd_hit ? limit_aux_pkg::RESP_OKAY : limit_aux_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence seq_aux_edge(logic [3:0] code);
		!aux_is_out && !aux_sense ##1 aux_sense && (in_action == code) && !aux_is_out;
	endsequence

	chk_halt_left: assert property (
		travel_limit_flags[limit_aux_pkg::STOP_LEFT] && at_left |=> halt_motor_o)
		else $error("left limit reached without halt");
	chk_halt_right: assert property (
		travel_limit_flags[limit_aux_pkg::STOP_RIGHT] && at_right |=> halt_motor_o)
		else $error("right limit reached without halt");
	chk_halt_none: assert property (
		travel_limit_flags[3:1] == 3'h0 |=> !halt_motor_o)
		else $error("halt raised with all stop flags clear");
	chk_switch_left_map: assert property (
		!travel_limit_flags[limit_aux_pkg::LIM_FROM_POS] && switch_config_flags[2:0] == 3'h1
		|=> at_left_limit_o == $past(second_switch_pin_i))
		else $error("swapped switches not mapped to left limit");
	chk_pos_source: assert property (
		travel_limit_flags[limit_aux_pkg::LIM_FROM_POS] && position_i == left_limit_pos
		&& position_fraction_i == left_limit_fraction |=> at_left_limit_o)
		else $error("position at left limit not flagged");
	chk_aux_oe: assert property (
		aux_is_out |=> aux_io_pin_oe_o && !stop_command_o && !alarm_set_o)
		else $error("aux output enable does not follow setup");
	chk_stop_pulse: assert property (
		seq_aux_edge(limit_aux_pkg::ACT_STOP) |=> stop_command_o ##1 !stop_command_o)
		else $error("stop pulse missing or too long");
	chk_wind_off: assert property (
		seq_aux_edge(limit_aux_pkg::ACT_WIND_OFF) |=> windings_off_command_o && !stop_command_o)
		else $error("winding power-off pulse missing");
	chk_alarm_set: assert property (
		seq_aux_edge(limit_aux_pkg::ACT_ALARM) |=> alarm_set_o && !home_command_o)
		else $error("alarm pulse missing");
	chk_out_moving: assert property (
		aux_is_out && out_source == limit_aux_pkg::OUT_MOVING && !aux_pin_setup[1]
		|=> aux_io_pin_o == $past(motor_moving_i))
		else $error("aux output does not follow motion");
	chk_answer_len: assert property (
		cmd_write && w_data == limit_aux_pkg::CMD_READ_LIMITS
		|=> sending && query_len == 5'h1a && query_idx == 5'h00)
		else $error("limits query answer not armed with 26 bytes");
endmodule

// >>> aux_far_end.sv
// far side of the aux pin: host-side source resolved with the device drive
module aux_far_end (
	// pin parties
	input wire logic oe_i,
	input wire logic drv_i,
	input wire logic ext_i,
	// resolved wire
	output logic pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pin_o = oe_i ? drv_i : ext_i;
endmodule

// >>> limit_border_and_aux_io_control_tb.sv
// self-checking bench for the travel-limit and aux pin controller
module limit_border_and_aux_io_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, reset_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, clr = 0;
	logic ext = 0, s1 = 0, s2 = 0, mov = 0, alm = 0, won = 0, fnd = 0;
	logic [7:0] awa = 0, ara = 0, lf, sf, src;
	logic [31:0] wd = 0, rd, d, lp, rp;
	logic [15:0] lfr, rfr;
	logic [1:0] br, rr, r;
	logic awr, wr, bv, arr, rv, po, poe, pin, al, ar, hlt, c_st, c_wo, c_rm, c_hm, c_al;
	logic [4:0] seen, ex;
	logic el, er;
	logic [31:0] pos = 0;
	logic [15:0] pfr = 0;
	int n_errors = 0, checked = 0;
	logic [7:0] q[$];
	limit_aux_ctrl u_limit_aux_ctrl (.core_clk_i(clk), .reset_n_i(reset_n),
		.s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
		.s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
		.position_i(pos), .position_fraction_i(pfr), .motor_moving_i(mov),
		.alarm_state_i(alm), .windings_on_i(won), .motor_found_i(fnd),
		.first_switch_pin_i(s1), .second_switch_pin_i(s2), .aux_io_pin_i(pin),
		.aux_io_pin_o(po), .aux_io_pin_oe_o(poe), .at_left_limit_o(al),
		.at_right_limit_o(ar), .halt_motor_o(hlt), .stop_command_o(c_st),
		.windings_off_command_o(c_wo), .relative_move_command_o(c_rm),
		.home_command_o(c_hm), .alarm_set_o(c_al));
	aux_far_end u_aux_far_end (.oe_i(poe), .drv_i(po), .ext_i(ext), .pin_o(pin));
	initial forever #10 clk = ~clk;
	// sticky record of command pulses, cleared on request
	always @(posedge clk) seen <= clr ? 5'h0 : seen | {c_al, c_hm, c_rm, c_wo, c_st};
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// position in 1/256 microsteps, signed whole steps plus signed fraction
	function automatic longint fn(input logic [31:0] p, input logic [15:0] f);
		return longint'($signed(p)) * 256 + longint'($signed(f));
	endfunction
	task automatic stop_test;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// axi write: each channel released at its own take edge
	task automatic wrr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw;
		@(posedge clk);
		{awa, wd, awv, wv, bre} <= {a, v, 3'h7};
		{ta, tw} = 2'h0;
		while (!(ta && tw)) begin
			@(posedge clk);
			ta |= awr;
			tw |= wr;
			if (ta) awv <= 0;
			if (tw) wv <= 0;
		end
		while (!bv) @(posedge clk);
		r = br;
		bre <= 0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		{ara, arv, rre} <= {a, 2'h3};
		do @(posedge clk); while (!arr);
		arv <= 0;
		while (!rv) @(posedge clk);
		d = rd;
		rre <= 0;
	endtask
	// model answer: command, fields, zeros, then reflected checksum
	task automatic query(input logic [31:0] cmd, input int nz);
		logic [15:0] c = 16'hffff;
		repeat (nz) q.push_back(8'h0);
		q = {cmd[7:0], cmd[15:8], cmd[23:16], cmd[31:24], q};
		foreach (q[i]) begin
			c ^= {8'h0, q[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		wrr(8'h1c, cmd);
		foreach (q[i]) begin
			rdr(8'h20);
			chk(d, {23'h0, 1'b1, q[i]});
		end
		rdr(8'h20);
		chk(d, 32'h0);
		q = {};
	endtask
	initial begin
		void'($urandom(32'h745d));
		repeat (12) @(posedge clk);
		reset_n <= 1;
		wrr(8'h3c, 32'h1);
		chk(r, 2'h2);
		rdr(8'h3c);
		chk(rr, 2'h2);
		chk(d, 32'h0);
		for (int i = 0; i < 32; i++) begin
			sf = 8'(i % 8);
			lf = 8'h2 << (i % 3);
			wrr(8'h00, {16'h0, sf, lf});
			{s1, s2} <= 2'(i / 8);
			repeat (4) @(posedge clk);
			{el, er} = sf[0] ? {s2 ^ sf[2], s1 ^ sf[1]} : {s1 ^ sf[1], s2 ^ sf[2]};
			chk({al, ar}, {el, er});
			chk(hlt, (lf[1] & el) | (lf[2] & er) | (lf[3] & (el | er)));
		end
		{lf, sf, lp, rp, lfr, rfr} = {$urandom, $urandom, $urandom, $urandom};
		lf[7:4] = 4'h0;
		sf[7:3] = 5'h0;
		wrr(8'h00, {16'h0, sf, lf});
		wrr(8'h04, lp);
		wrr(8'h08, {16'h0, lfr});
		wrr(8'h0c, rp);
		wrr(8'h10, {16'h0, rfr});
		q = {lf, sf, lp[7:0], lp[15:8], lp[23:16], lp[31:24], lfr[7:0], lfr[15:8]};
		q = {q, rp[7:0], rp[15:8], rp[23:16], rp[31:24], rfr[7:0], rfr[15:8]};
		query(32'h73646567, 6);
		// position-defined limits, stop at both sides, around each limit
		wrr(8'h00, 32'h0000_0007);
		for (int k = 0; k < 6; k++) begin
			pos <= (k < 3 ? lp : rp) + 32'(k % 3) - 32'h1;
			pfr <= (k < 3) ? lfr : rfr;
			repeat (3) @(posedge clk);
			el = (fn(pos, pfr) <= fn(lp, lfr));
			er = (fn(pos, pfr) >= fn(rp, rfr));
			chk({al, ar, hlt}, {el, er, el | er});
		end
		for (int i = 0; i < 16; i++) begin
			ext <= i[3];
			wrr(8'h14, {16'h0, 8'(i % 8), 6'h0, i[3], 1'b0});
			clr <= 1;
			@(posedge clk);
			{clr, ext} <= {1'b0, ~i[3]};
			repeat (5) @(posedge clk);
			ex = (i % 8 inside {[1:5]}) ? 5'(1 << (i % 8 - 1)) : 5'h0;
			chk(poe, 1'b0);
			chk(seen, ex);
		end
		for (int i = 0; i < 16; i++) begin
			{mov, alm, won, fnd} <= 4'($urandom);
			wrr(8'h14, {16'h0, 4'(i % 8), 4'h0, 6'h0, i[3], 1'b1});
			repeat (3) @(posedge clk);
			src = {2'h0, fnd, won, alm, mov, 2'h2};
			chk({poe, po}, {1'b1, src[i % 8] ^ i[3]});
		end
		{lf, sf} = 16'($urandom);
		wrr(8'h14, {16'h0, sf, 6'h0, lf[1:0]});
		q = {8'(lf[1:0]), sf};
		query(32'h6f696567, 10);
		stop_test;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		stop_test;
	end
endmodule
